// ### inc/efac_consts.svh
`ifndef EFAC_CONSTS_SVH
`define EFAC_CONSTS_SVH

// bus and array geometry
`define EFAC_ADDR_W 16
`define EFAC_DATA_W 8
`define EFAC_IDX_W 14
`define EFAC_MAIN_BYTES 8192
`define EFAC_VEC_BYTES 34
`define EFAC_ARRAY_DEPTH 8256
`define EFAC_PAGE_BYTES 64
`define EFAC_ROW_BYTES 32
`define EFAC_PAGE_LSB 6
`define EFAC_ROW_LSB 5

// address map
`define EFAC_MAIN_BASE 16'hDE00
`define EFAC_MAIN_LAST 16'hFDFF
`define EFAC_VEC_BASE 16'hFFDE
`define EFAC_CTRL_ADDR 16'hFE08
`define EFAC_PROT_ADDR 16'hFF7E
`define EFAC_TRIM_ADDR 16'hFFC0
`define EFAC_WDOG_ADDR 16'hFFFF

// slots of the extra bytes behind the main array
`define EFAC_VEC_IDX 14'h2000
`define EFAC_TRIM_IDX 14'h2022
`define EFAC_PROT_IDX 14'h2023
`define EFAC_LAST_IDX 14'h203F

// control register fields
`define EFAC_PGM_BIT 0
`define EFAC_ERASE_BIT 1
`define EFAC_MASS_BIT 2
`define EFAC_HIGH_VOLTAGE_ENABLE_BIT 3

// values
`define EFAC_ERASED 8'hFF
`define EFAC_PROT_NONE 8'hFF
`define EFAC_BUSY_DATA 8'hFF
`define EFAC_UNMAPPED_DATA 8'h00

// timing
`define EFAC_CLK_NS 25
`define EFAC_T_NVS_NS 10000
`define EFAC_T_PGS_NS 5000
`define EFAC_T_RCV_NS 1000
`define EFAC_NVS_CYC ((`EFAC_T_NVS_NS + `EFAC_CLK_NS - 1) / `EFAC_CLK_NS)
`define EFAC_PGS_CYC ((`EFAC_T_PGS_NS + `EFAC_CLK_NS - 1) / `EFAC_CLK_NS)
`define EFAC_RCV_CYC ((`EFAC_T_RCV_NS + `EFAC_CLK_NS - 1) / `EFAC_CLK_NS)
`define EFAC_TMR_W 16

`endif

// ### inc/efac_pkg.sv
`include "efac_consts.svh"

package efac_pkg;

  typedef enum logic [2:0] {
    EFAC_IDLE = 3'h0,
    EFAC_ARMED = 3'h1,
    EFAC_PROT_READ = 3'h3,
    EFAC_LATCHED = 3'h2,
    EFAC_HV_ON = 3'h6,
    EFAC_RECOVER = 3'h7
  } efac_seq_t;

  typedef struct packed {
    logic program_select;
    logic erase;
    logic mass;
    logic high_voltage_enable;
    efac_seq_t seq;
    logic [`EFAC_IDX_W-1:0] lat_idx;
    logic [`EFAC_TMR_W-1:0] tmr;
    logic walking;
    logic [`EFAC_IDX_W-1:0] walk;
    logic [`EFAC_IDX_W-1:0] walk_end;
    logic [`EFAC_DATA_W-1:0] prot_shadow;
    logic [`EFAC_DATA_W-1:0] rdata;
    logic wdog_clear;
    logic pump_on;
    logic busy;
  } efac_state_t;

endpackage

// ### rtl/efac_array.sv
`timescale 1ns/10ps
`include "efac_consts.svh"

module efac_array #(
  parameter int DEPTH = `EFAC_ARRAY_DEPTH,
  parameter int AW = `EFAC_IDX_W,
  parameter int DW = `EFAC_DATA_W
) (
  // clock
  input wire logic mclk,
  // cell operations
  input wire logic op_prog,
  input wire logic op_erase,
  input wire logic [AW-1:0] op_addr,
  input wire logic [DW-1:0] op_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_word
);

  // no reset: contents are non-volatile and survive every reset
  logic [DW-1:0] cells [DEPTH];

  always_ff @(posedge mclk) begin
    if (op_erase) begin
      cells[op_addr] <= '1; // erase drives a cell to all ones
    end else if (op_prog) begin
      // programming only pulls bits to zero
      cells[op_addr] <= cells[op_addr] & op_data;
    end
  end

  assign rd_word = cells[rd_addr];

endmodule

// ### rtl/efac_top.sv
`timescale 1ns/10ps
`include "efac_consts.svh"

module efac_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // cpu bus
  input wire logic [`EFAC_ADDR_W-1:0] bus_addr,
  input wire logic [`EFAC_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [`EFAC_DATA_W-1:0] bus_rdata,
  // system side
  output logic watchdog_clear,
  output logic pump_on,
  output logic flash_busy
);
  import efac_pkg::*;

  efac_state_t st_reg;
  efac_state_t st_next;

  logic arr_prog;
  logic arr_erase;
  logic [`EFAC_IDX_W-1:0] arr_addr;
  logic [`EFAC_DATA_W-1:0] arr_data;
  logic [`EFAC_IDX_W-1:0] arr_raddr;
  logic [`EFAC_DATA_W-1:0] arr_word;
  logic [`EFAC_IDX_W:0] map_res;
  logic map_hit;
  logic [`EFAC_IDX_W-1:0] map_idx;
  logic req_pgm;
  logic req_erase;
  logic req_mass;
  logic req_high_voltage_enable;
  logic [`EFAC_IDX_W-1:0] page_base;

  // bus address to cell index; hit is the top bit
  function automatic logic [`EFAC_IDX_W:0] efac_map(input logic [`EFAC_ADDR_W-1:0] a);
    logic [`EFAC_ADDR_W-1:0] off;
    off = '0;
    if (a >= `EFAC_MAIN_BASE && a <= `EFAC_MAIN_LAST) begin
      off = a - `EFAC_MAIN_BASE;
      return {1'b1, off[`EFAC_IDX_W-1:0]};
    end else if (a >= `EFAC_VEC_BASE) begin
      off = a - `EFAC_VEC_BASE;
      return {1'b1, `EFAC_VEC_IDX + off[`EFAC_IDX_W-1:0]};
    end else if (a == `EFAC_TRIM_ADDR) begin
      return {1'b1, `EFAC_TRIM_IDX}; // trim lives in the vector page
    end else if (a == `EFAC_PROT_ADDR) begin
      return {1'b1, `EFAC_PROT_IDX};
    end
    return '0;
  endfunction

  // row and page numbers; a page index drops one more bit than a row, so two rows per page
  function automatic logic [`EFAC_IDX_W-1:0] efac_row(input logic [`EFAC_IDX_W-1:0] i);
    return i >> `EFAC_ROW_LSB;
  endfunction

  function automatic logic [`EFAC_IDX_W-1:0] efac_page(input logic [`EFAC_IDX_W-1:0] i);
    return i >> `EFAC_PAGE_LSB;
  endfunction

  assign map_res = efac_map(bus_addr);
  assign map_hit = map_res[`EFAC_IDX_W];
  assign map_idx = map_res[`EFAC_IDX_W-1:0];
  assign arr_raddr = map_idx;
  assign req_pgm = bus_wdata[`EFAC_PGM_BIT];
  assign req_erase = bus_wdata[`EFAC_ERASE_BIT];
  assign req_mass = bus_wdata[`EFAC_MASS_BIT];
  assign req_high_voltage_enable = bus_wdata[`EFAC_HIGH_VOLTAGE_ENABLE_BIT];
  assign page_base = efac_page(st_reg.lat_idx) << `EFAC_PAGE_LSB;

  efac_array #(
    .DEPTH(`EFAC_ARRAY_DEPTH),
    .AW(`EFAC_IDX_W),
    .DW(`EFAC_DATA_W)
  ) u_array (
    .mclk(mclk),
    .op_prog(arr_prog),
    .op_erase(arr_erase),
    .op_addr(arr_addr),
    .op_data(arr_data),
    .rd_addr(arr_raddr),
    .rd_word(arr_word)
  );

  always_comb begin
    st_next = st_reg;
    st_next.wdog_clear = 1'b0;
    arr_prog = 1'b0;
    arr_erase = 1'b0;
    arr_addr = st_reg.walk;
    arr_data = bus_wdata;

    if (st_reg.tmr != '0) begin
      st_next.tmr = st_reg.tmr - 1'b1;
    end

    // erase walks one cell per clock while the pump is on
    if (st_reg.walking) begin
      arr_erase = 1'b1;
      if (st_reg.walk == st_reg.walk_end) begin
        st_next.walking = 1'b0;
      end else begin
        st_next.walk = st_reg.walk + 1'b1;
      end
    end

    case (st_reg.seq)
      EFAC_RECOVER: begin
        if (st_reg.tmr == '0) begin
          if (st_reg.program_select || st_reg.erase) begin
            st_next.seq = EFAC_ARMED;
          end else begin
            st_next.seq = EFAC_IDLE;
          end
        end
      end
      EFAC_IDLE, EFAC_ARMED, EFAC_PROT_READ, EFAC_LATCHED, EFAC_HV_ON: begin
      end
      default: begin
        st_next.seq = EFAC_IDLE;
      end
    endcase

    if (bus_rd) begin
      if (st_reg.seq == EFAC_HV_ON || st_reg.seq == EFAC_RECOVER) begin
        st_next.rdata = `EFAC_BUSY_DATA; // array not readable
      end else if (bus_addr == `EFAC_CTRL_ADDR) begin
        st_next.rdata = '0;
        st_next.rdata[`EFAC_PGM_BIT] = st_reg.program_select;
        st_next.rdata[`EFAC_ERASE_BIT] = st_reg.erase;
        st_next.rdata[`EFAC_MASS_BIT] = st_reg.mass;
        st_next.rdata[`EFAC_HIGH_VOLTAGE_ENABLE_BIT] = st_reg.high_voltage_enable;
      end else if (map_hit) begin
        // top vector location reads back as plain array data
        st_next.rdata = arr_word;
      end else begin
        st_next.rdata = `EFAC_UNMAPPED_DATA;
      end
      // reading the protection byte is the second step of the sequence
      if (bus_addr == `EFAC_PROT_ADDR && st_reg.seq == EFAC_ARMED) begin
        st_next.seq = EFAC_PROT_READ;
        st_next.prot_shadow = arr_word;
      end
    end

    if (bus_wr) begin
      if (bus_addr == `EFAC_CTRL_ADDR) begin
        // a write asking for both selects is ignored for both
        if (!(req_pgm && req_erase)) begin
          st_next.program_select = req_pgm;
          st_next.erase = req_erase;
        end
        st_next.mass = req_mass;
        if (req_high_voltage_enable && !st_reg.high_voltage_enable) begin
          // pump only after select, protect read, latch and setup time
          if ((st_next.program_select || st_next.erase) && st_reg.seq == EFAC_LATCHED && st_reg.tmr == '0) begin
            st_next.high_voltage_enable = 1'b1;
            st_next.seq = EFAC_HV_ON;
            st_next.tmr = `EFAC_TMR_W'(`EFAC_PGS_CYC);
            if (st_next.erase) begin
              if (st_next.mass) begin
                // protected blocks forbid mass erase
                if (st_reg.prot_shadow == `EFAC_PROT_NONE) begin
                  st_next.walking = 1'b1;
                  st_next.walk = '0;
                  st_next.walk_end = `EFAC_LAST_IDX;
                end
              end else if (st_reg.lat_idx < `EFAC_VEC_IDX) begin
                // vector page only goes by mass erase
                st_next.walking = 1'b1;
                st_next.walk = page_base;
                st_next.walk_end = page_base | `EFAC_IDX_W'(`EFAC_PAGE_BYTES - 1);
              end
            end
          end
        end else if (!req_high_voltage_enable && st_reg.high_voltage_enable) begin
          // dropping the pump aborts any erase still walking
          st_next.high_voltage_enable = 1'b0;
          st_next.walking = 1'b0;
          st_next.seq = EFAC_RECOVER;
          st_next.tmr = `EFAC_TMR_W'(`EFAC_RCV_CYC);
        end
        if (!st_reg.program_select && !st_reg.erase && (st_next.program_select || st_next.erase) && st_reg.seq == EFAC_IDLE) begin
          st_next.seq = EFAC_ARMED;
        end
        if (!st_next.program_select && !st_next.erase && !st_next.high_voltage_enable && st_reg.seq != EFAC_RECOVER
            && st_reg.seq != EFAC_HV_ON) begin
          st_next.seq = EFAC_IDLE;
        end
      end else if (map_hit) begin
        if (bus_addr == `EFAC_WDOG_ADDR) begin
          st_next.wdog_clear = 1'b1; // any value clears the watchdog
        end
        if (st_reg.seq == EFAC_PROT_READ && (st_reg.program_select || st_reg.erase)) begin
          st_next.lat_idx = map_idx; // chooses the row or page
          st_next.seq = EFAC_LATCHED;
          st_next.tmr = `EFAC_TMR_W'(`EFAC_NVS_CYC);
        end else if (st_reg.seq == EFAC_HV_ON && st_reg.program_select && st_reg.tmr == '0
                     && bus_addr != `EFAC_WDOG_ADDR
                     && efac_row(map_idx) == efac_row(st_reg.lat_idx)) begin
          // bytes outside the latched row are dropped
          arr_prog = 1'b1;
          arr_addr = map_idx;
        end
      end
    end

    st_next.pump_on = st_next.high_voltage_enable;
    st_next.busy = (st_next.seq == EFAC_HV_ON) || (st_next.seq == EFAC_RECOVER);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '{
        program_select: 1'b0,
        erase: 1'b0,
        mass: 1'b0,
        high_voltage_enable: 1'b0,
        seq: EFAC_IDLE,
        lat_idx: '0,
        tmr: '0,
        walking: 1'b0,
        walk: '0,
        walk_end: '0,
        prot_shadow: 8'h00,
        rdata: 8'h00,
        wdog_clear: 1'b0,
        pump_on: 1'b0,
        busy: 1'b0
      };
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;
  assign watchdog_clear = st_reg.wdog_clear;
  assign pump_on = st_reg.pump_on;
  assign flash_busy = st_reg.busy;

endmodule

// ### verification/efac_top_monitor.sv
`timescale 1ns/10ps
`include "efac_consts.svh"

module efac_top_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // cpu bus
  input wire logic [`EFAC_ADDR_W-1:0] bus_addr,
  input wire logic [`EFAC_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [`EFAC_DATA_W-1:0] bus_rdata,
  // system side
  input wire logic watchdog_clear,
  input wire logic pump_on,
  input wire logic flash_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire ctl_wr = bus_wr && bus_addr == `EFAC_CTRL_ADDR;

  property p_wdog_pulse;
    bus_wr && bus_addr == `EFAC_WDOG_ADDR |=> watchdog_clear;
  endproperty
  a_wdog_pulse: assert property (p_wdog_pulse) else $error("watchdog clear missing");
  property p_wdog_cause;
    watchdog_clear |-> $past(bus_wr) && $past(bus_addr) == `EFAC_WDOG_ADDR;
  endproperty
  a_wdog_cause: assert property (p_wdog_cause) else $error("stray watchdog clear");
  property p_pump_cause;
    $rose(pump_on) |-> $past(ctl_wr && bus_wdata[`EFAC_HIGH_VOLTAGE_ENABLE_BIT]);
  endproperty
  a_pump_cause: assert property (p_pump_cause) else $error("pump on without high_voltage_enable write");
  property p_pump_off;
    ctl_wr && !bus_wdata[`EFAC_HIGH_VOLTAGE_ENABLE_BIT] |=> !pump_on;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump stays on");
  property p_pump_busy;
    pump_on |-> flash_busy;
  endproperty
  a_pump_busy: assert property (p_pump_busy) else $error("not busy under high voltage");
  property p_hold;
    $fell(pump_on) |-> flash_busy[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("recovery cut short");
  property p_release;
    $fell(pump_on) |-> ##[38:44] !flash_busy;
  endproperty
  a_release: assert property (p_release) else $error("recovery too long");
  property p_busy_read;
    bus_rd && pump_on |=> bus_rdata == `EFAC_BUSY_DATA;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("read not suspended");
  property p_ctrl_read;
    bus_rd && bus_addr == `EFAC_CTRL_ADDR && !flash_busy |=> bus_rdata[7:4] == 4'h0 && !(bus_rdata[0] && bus_rdata[1]);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("select bits both set");
  property p_unmapped;
    bus_rd && bus_addr == 16'h0000 && !flash_busy |=> bus_rdata == `EFAC_UNMAPPED_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
endmodule

bind efac_top efac_top_monitor u_mon (.mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .watchdog_clear(watchdog_clear),
  .pump_on(pump_on), .flash_busy(flash_busy));

// ### verification/efac_cpu_model.sv
`timescale 1ns/10ps
`include "efac_consts.svh"

module efac_cpu_model (
  // clock
  input wire logic mclk,
  // cpu bus
  output logic [`EFAC_ADDR_W-1:0] bus_addr,
  output logic [`EFAC_DATA_W-1:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [`EFAC_DATA_W-1:0] bus_rdata
);
  initial begin
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus_wr <= 1'h1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge mclk);
    bus_wr <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge mclk);
    bus_rd <= 1'h1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'h0;
    // data stands from the cycle after the strobe until the next read
    @(posedge mclk);
    v = bus_rdata;
  endtask
endmodule

// ### verification/efac_top_tb.sv
`timescale 1ns/10ps
`include "efac_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module efac_top_tb;
  logic mclk;
  logic rst;
  logic [`EFAC_ADDR_W-1:0] bus_addr;
  logic [`EFAC_DATA_W-1:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [`EFAC_DATA_W-1:0] bus_rdata;
  logic watchdog_clear;
  logic pump_on;
  logic flash_busy;
  logic [7:0] d;
  int failures = 0;
  int checks = 0;

  efac_top DUT (.mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .watchdog_clear(watchdog_clear), .pump_on(pump_on),
    .flash_busy(flash_busy));
  efac_cpu_model cpu (.mclk(mclk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    cpu.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // select, protect read, latch, settle, then high voltage
  task automatic arm(input logic [7:0] sel, input logic [15:0] a);
    cpu.wr(`EFAC_CTRL_ADDR, sel);
    cpu.rd(`EFAC_PROT_ADDR, d);
    cpu.wr(a, 8'h00);
    wait_cyc(401);
    cpu.wr(`EFAC_CTRL_ADDR, sel | 8'h08);
    #1;
    `CHK(pump_on, 1'h1)
  endtask
  task automatic disarm;
    cpu.wr(`EFAC_CTRL_ADDR, 8'h08);
    cpu.wr(`EFAC_CTRL_ADDR, 8'h00);
    #1;
    `CHK(flash_busy, 1'h1)
    wait_cyc(44);
    `CHK(flash_busy, 1'h0)
  endtask

  task automatic t_reset;
    `CHK(pump_on, 1'h0)
    `CHK(watchdog_clear, 1'h0)
    rd_chk(`EFAC_CTRL_ADDR, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_ctrl;
    cpu.wr(`EFAC_CTRL_ADDR, 8'hF1);
    rd_chk(`EFAC_CTRL_ADDR, 8'h01);
    cpu.wr(`EFAC_CTRL_ADDR, 8'h03);
    rd_chk(`EFAC_CTRL_ADDR, 8'h01);
    cpu.wr(`EFAC_CTRL_ADDR, 8'h00);
    cpu.wr(`EFAC_CTRL_ADDR, 8'h06);
    // a refused double select still takes the mass bit from the same write
    cpu.wr(`EFAC_CTRL_ADDR, 8'h03);
    rd_chk(`EFAC_CTRL_ADDR, 8'h02);
    cpu.wr(`EFAC_CTRL_ADDR, 8'h07);
    rd_chk(`EFAC_CTRL_ADDR, 8'h06);
    cpu.wr(`EFAC_CTRL_ADDR, 8'h00);
    // high_voltage_enable out of sequence must be refused
    cpu.wr(`EFAC_CTRL_ADDR, 8'h08);
    #1;
    `CHK(pump_on, 1'h0)
    rd_chk(`EFAC_CTRL_ADDR, 8'h00);
    $display("test control done");
  endtask
  task automatic t_wdog;
    cpu.wr(`EFAC_WDOG_ADDR, 8'h5A);
    #1;
    `CHK(watchdog_clear, 1'h1)
    wait_cyc(1);
    `CHK(watchdog_clear, 1'h0)
    $display("test watchdog done");
  endtask
  task automatic t_erase;
    arm(8'h02, 16'hDE10);
    rd_chk(16'hDE00, `EFAC_BUSY_DATA);
    wait_cyc(80);
    disarm();
    rd_chk(16'hDE00, 8'hFF);
    rd_chk(16'hDE3F, 8'hFF);
    rd_chk(16'hDE20, 8'hFF);
    $display("test erase done");
  endtask
  task automatic t_prog;
    arm(8'h01, 16'hDE00);
    wait_cyc(201);
    cpu.wr(16'hDE05, 8'hA5);
    // second row in the same pass is dropped
    cpu.wr(16'hDE25, 8'h00);
    disarm();
    rd_chk(16'hDE05, 8'hA5);
    rd_chk(16'hDE25, 8'hFF);
    rd_chk(16'hDE04, 8'hFF);
    $display("test program done");
  endtask
  task automatic t_map;
    cpu.wr(16'h0000, 8'h55);
    rd_chk(16'h0000, `EFAC_UNMAPPED_DATA);
    rd_chk(16'hFE00, `EFAC_UNMAPPED_DATA);
    $display("test map done");
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst = 1'h1;
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    wait_cyc(1);
    t_reset();
    t_ctrl();
    t_wdog();
    t_erase();
    t_prog();
    t_map();
    results();
  end

  // whole run needs about 1300 cycles
  initial begin
    repeat (10000) @(posedge mclk);
    failures++;
    results();
  end
endmodule
